//--- verilog/fapd_pkg.sv
// Shared constants and carriers for the floppy auto powerdown controller.
package fapd_pkg;

  // Register indices; byte address is four times the index.
  localparam logic [3:0] IDX_STATUS_A  = 4'h0;
  localparam logic [3:0] IDX_STATUS_B  = 4'h1;
  localparam logic [3:0] IDX_DRV_OUT   = 4'h2;
  localparam logic [3:0] IDX_RATE_MAIN = 4'h4;
  localparam logic [3:0] IDX_CMD_DATA  = 4'h5;
  localparam logic [3:0] IDX_DIN_CCR   = 4'h7;
  localparam logic [3:0] IDX_PD_CFG    = 4'h8;
  localparam logic [3:0] IDX_PD_STAT   = 4'h9;

  // Field positions.
  localparam int DOR_MOTOR_LO = 4;
  localparam int DOR_MOTOR_HI = 7;
  localparam int DOR_NRESET   = 2;
  localparam int DSR_SWRESET  = 7;
  localparam int DSR_PDOWN    = 6;
  localparam int CFG_AUTO_EN  = 0;
  localparam int CFG_DIRECT   = 1;

  // Reset values.
  localparam logic [7:0] DOR_RESET = 8'h04;
  localparam logic [7:0] DSR_RESET = 8'h02;
  localparam logic [7:0] CCR_RESET = 8'h02;
  localparam logic [1:0] CFG_RESET = 2'h0;

  // Idle main status value.
  localparam logic [7:0] MSR_IDLE = 8'h80;

  // Timing.
  localparam int CLK_HZ     = 20000000;
  localparam int PD_TIME_MS = 10;
  localparam int PD_CYCLES  = PD_TIME_MS * (CLK_HZ / 1000);

  // Powerdown states.
  typedef enum logic [1:0] {
    ST_RUN,
    ST_AUTO_PD,
    ST_DIRECT_PD
  } fapd_state_e;

  // Drive outputs that float in powerdown, active low.
  typedef struct packed {
    logic [3:0] motor_n;
    logic [3:0] sel_n;
    logic       wdata_n;
    logic       wgate_n;
  } fapd_drv_s;

  // Drive outputs that stay active in powerdown.
  typedef struct packed {
    logic       dir_n;
    logic       step_n;
    logic       hdsel_n;
    logic [1:0] density;
  } fapd_act_s;

endpackage : fapd_pkg

//--- verilog/fapd_ctrl.sv
// Floppy controller auto powerdown and wake sequencer with an AHB-Lite register slave.
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module fapd_ctrl #(
  parameter int PD_CYCLES = fapd_pkg::PD_CYCLES
) (
  // Clock, reset and clock enable.
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             ce,
  // AHB-Lite slave.
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic [31:0]           hrdata,
  // Status from the controller core.
  input  wire logic [7:0]       status_a,
  input  wire logic [7:0]       status_b,
  input  wire logic [7:0]       main_status,
  input  wire logic [7:0]       drive_input_status,
  input  wire logic [7:0]       cmd_rd_data,
  input  wire logic             core_int,
  input  wire logic             head_unload_expired,
  // Drive signals produced by the core.
  input  wire logic             core_wdata_n,
  input  wire logic             core_wgate_n,
  input  wire fapd_pkg::fapd_act_s core_act,
  // Controls toward the core.
  output logic [7:0]            drive_output_control,
  output logic [7:0]            rate_select,
  output logic [7:0]            rate_config_control,
  output logic                  cmd_wr_strobe,
  output logic                  cmd_rd_strobe,
  output logic [7:0]            cmd_wr_data,
  output logic                  core_reset,
  output logic                  fdc_powered_down,
  // Drive pins.
  output fapd_pkg::fapd_drv_s   drv,
  output fapd_pkg::fapd_drv_s   drv_oe,
  output fapd_pkg::fapd_act_s   act
);

  localparam int TW = $clog2(PD_CYCLES + 1);
  localparam logic [TW-1:0] T_LAST = TW'(PD_CYCLES - 1);

  fapd_pkg::fapd_state_e state;
  fapd_pkg::fapd_state_e next_state;

  logic          dphase;
  logic          dwait;
  logic          a_write;
  logic [3:0]    a_idx;
  logic          a_map;
  logic [7:0]    dor_q;
  logic [7:0]    dsr_q;
  logic [7:0]    ccr_q;
  logic [1:0]    cfg_q;
  logic [TW-1:0] tcnt;
  logic          t_done;
  logic          wr_dor;
  logic          wr_dsr;
  logic          wr_ccr;
  logic          wr_cfg;
  logic          rd_msr;
  logic          acc_data;
  logic          motor_wake;
  logic          sw_reset;
  logic          wake;
  logic          auto_en;
  logic          direct_pd;
  logic          conds;
  logic          in_pd;
  logic [7:0]    rd_byte;

  // Address phase is taken when selected with a non-sequential or sequential transfer.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dphase  <= 1'b0;
      a_write <= 1'b0;
      a_idx   <= 4'h0;
      a_map   <= 1'b0;
    end else if (ce) begin
      if (hready && hsel && htrans[1]) begin
        dphase  <= 1'b1;
        a_write <= hwrite;
        a_idx   <= haddr[5:2];
        a_map   <= (haddr[31:6] == 26'h0) && (haddr[1:0] == 2'h0);
      end else if (hreadyout) begin
        dphase  <= 1'b0;
      end
    end
  end

  // The data phase holds one wait cycle so that read data comes from a flop.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      dwait     <= 1'b0;
    end else if (ce) begin
      if (hready && hsel && htrans[1]) begin
        hreadyout <= 1'b0;
        dwait     <= 1'b1;
      end else begin
        hreadyout <= 1'b1;
        dwait     <= 1'b0;
      end
    end
  end

  // Every access completes with an OKAY response.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else if (ce) begin
      hresp <= 1'b0;
    end
  end

  // Decode of the wait cycle, where write data and read sources are valid.
  assign wr_dor   = dwait && a_map && a_write && (a_idx == fapd_pkg::IDX_DRV_OUT);
  assign wr_dsr   = dwait && a_map && a_write && (a_idx == fapd_pkg::IDX_RATE_MAIN);
  assign wr_ccr   = dwait && a_map && a_write && (a_idx == fapd_pkg::IDX_DIN_CCR);
  assign wr_cfg   = dwait && a_map && a_write && (a_idx == fapd_pkg::IDX_PD_CFG);
  assign rd_msr   = dwait && a_map && !a_write && (a_idx == fapd_pkg::IDX_RATE_MAIN);
  assign acc_data = dwait && a_map && (a_idx == fapd_pkg::IDX_CMD_DATA);

  // Wake and reset sources; other writes to these registers do not wake from auto powerdown.
  assign motor_wake = wr_dor
                   && (hwdata[fapd_pkg::DOR_MOTOR_HI:fapd_pkg::DOR_MOTOR_LO] != 4'h0);
  assign sw_reset   = (wr_dor && !hwdata[fapd_pkg::DOR_NRESET])
                   || (wr_dsr && hwdata[fapd_pkg::DSR_SWRESET]);
  assign wake       = motor_wake || rd_msr || acc_data || sw_reset;

  assign auto_en   = cfg_q[fapd_pkg::CFG_AUTO_EN];
  assign direct_pd = dsr_q[fapd_pkg::DSR_PDOWN] || cfg_q[fapd_pkg::CFG_DIRECT];
  assign in_pd     = (state != fapd_pkg::ST_RUN);

  // Idle conditions use the values the core currently sees.
  assign conds = (drive_output_control[fapd_pkg::DOR_MOTOR_HI:fapd_pkg::DOR_MOTOR_LO] == 4'h0)
              && (main_status == fapd_pkg::MSR_IDLE) && !core_int
              && head_unload_expired;

  // Host copies of the written registers; stored at once, even in powerdown.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dor_q <= fapd_pkg::DOR_RESET;
      dsr_q <= fapd_pkg::DSR_RESET;
      ccr_q <= fapd_pkg::CCR_RESET;
      cfg_q <= fapd_pkg::CFG_RESET;
    end else if (ce) begin
      if (wr_dor) begin
        dor_q <= hwdata[7:0];
      end
      if (wr_dsr) begin
        dsr_q <= hwdata[7:0];
      end else if (sw_reset) begin
        dsr_q[fapd_pkg::DSR_PDOWN] <= 1'b0;
      end
      if (wr_ccr) begin
        ccr_q <= hwdata[7:0];
      end
      if (wr_cfg) begin
        cfg_q <= hwdata[1:0];
      end
    end
  end

  // The core sees new register values only while awake.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_output_control <= fapd_pkg::DOR_RESET;
      rate_select          <= fapd_pkg::DSR_RESET;
      rate_config_control  <= fapd_pkg::CCR_RESET;
    end else if (ce) begin
      if (!in_pd) begin
        drive_output_control <= dor_q;
        rate_select          <= dsr_q;
        rate_config_control  <= ccr_q;
      end
    end
  end

  // Auto powerdown timer counts only while enabled, awake and idle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tcnt <= '0;
    end else if (ce) begin
      if (state != fapd_pkg::ST_RUN || !auto_en || !conds || direct_pd || wake) begin
        tcnt <= '0;
      end else if (tcnt != T_LAST) begin
        tcnt <= tcnt + TW'(1);
      end
    end
  end

  assign t_done = (tcnt == T_LAST);

  // Powerdown state selection.
  always_comb begin
    next_state = state;
    case (state)
      fapd_pkg::ST_RUN: begin
        if (direct_pd) begin
          next_state = fapd_pkg::ST_DIRECT_PD;
        end else if (auto_en && conds && t_done && !wake) begin
          next_state = fapd_pkg::ST_AUTO_PD;
        end
      end
      fapd_pkg::ST_AUTO_PD: begin
        if (direct_pd) begin
          next_state = fapd_pkg::ST_DIRECT_PD;
        end else if (wake || !auto_en) begin
          next_state = fapd_pkg::ST_RUN;
        end
      end
      fapd_pkg::ST_DIRECT_PD: begin
        if (!direct_pd) begin
          next_state = fapd_pkg::ST_RUN;
        end
      end
      default: begin
        next_state = fapd_pkg::ST_RUN;
      end
    endcase
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= fapd_pkg::ST_RUN;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Powerdown flag toward the core.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fdc_powered_down <= 1'b0;
    end else if (ce) begin
      fdc_powered_down <= (next_state != fapd_pkg::ST_RUN);
    end
  end

  // Core reset is held through hardware reset and pulsed for software reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_reset <= 1'b1;
    end else if (ce) begin
      core_reset <= sw_reset;
    end
  end

  // Command data strobes toward the core.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_wr_strobe <= 1'b0;
      cmd_rd_strobe <= 1'b0;
      cmd_wr_data   <= 8'h00;
    end else if (ce) begin
      cmd_wr_strobe <= acc_data && a_write;
      cmd_rd_strobe <= acc_data && !a_write;
      if (acc_data && a_write) begin
        cmd_wr_data <= hwdata[7:0];
      end
    end
  end

  // Read multiplexer; status inputs are live even in powerdown.
  always_comb begin
    rd_byte = 8'h00;
    if (a_map) begin
      case (a_idx)
        fapd_pkg::IDX_STATUS_A:  rd_byte = status_a;
        fapd_pkg::IDX_STATUS_B:  rd_byte = status_b;
        fapd_pkg::IDX_DRV_OUT:   rd_byte = drive_output_control;
        fapd_pkg::IDX_RATE_MAIN: rd_byte = main_status;
        fapd_pkg::IDX_CMD_DATA:  rd_byte = cmd_rd_data;
        fapd_pkg::IDX_DIN_CCR:   rd_byte = drive_input_status;
        fapd_pkg::IDX_PD_CFG:    rd_byte = {6'h00, cfg_q};
        fapd_pkg::IDX_PD_STAT:   rd_byte = {4'h0, t_done, conds,
                                            (state == fapd_pkg::ST_DIRECT_PD),
                                            (state == fapd_pkg::ST_AUTO_PD)};
        default:                 rd_byte = 8'h00;
      endcase
    end
  end

  // Read data is registered in the wait cycle and held until the next read.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ce) begin
      if (dwait && !a_write) begin
        hrdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Drive pins: floating group released in powerdown, active group passed through.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drv    <= '1;
      drv_oe <= '0;
      act    <= '1;
    end else if (ce) begin
      drv.motor_n <= ~drive_output_control[fapd_pkg::DOR_MOTOR_HI:fapd_pkg::DOR_MOTOR_LO];
      drv.sel_n   <= ~(4'h1 << drive_output_control[1:0]);
      drv.wdata_n <= core_wdata_n;
      drv.wgate_n <= core_wgate_n;
      drv_oe      <= (next_state != fapd_pkg::ST_RUN) ? '0 : '1;
      act         <= core_act;
    end
  end

endmodule : fapd_ctrl

`default_nettype wire

//--- verification/fapd_ctrl_props.sv
// Concurrent checks on the ports of the floppy auto powerdown controller.
`timescale 1ns/1ps
`default_nettype none
module fapd_ctrl_props #(
  parameter int PD_CYCLES = 20
) (
  // Clock and reset.
  input wire logic                hclk,
  input wire logic                hresetn,
  // Register bus.
  input wire logic                hsel,
  input wire logic [31:0]         haddr,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic [31:0]         hwdata,
  input wire logic                hready,
  input wire logic                hreadyout,
  input wire logic                hresp,
  // Core status and drive signals.
  input wire logic [7:0]          main_status,
  input wire logic                core_int,
  input wire logic                head_unload_expired,
  input wire fapd_pkg::fapd_act_s core_act,
  // Controller outputs.
  input wire logic [7:0]          drive_output_control,
  input wire logic                core_reset,
  input wire logic                fdc_powered_down,
  input wire fapd_pkg::fapd_drv_s drv_oe,
  input wire fapd_pkg::fapd_act_s act
);
  logic       taken;
  logic [7:0] wr_addr;
  logic       direct_seen;
  logic [7:0] idle_run;
  // A transfer is taken when its address phase meets hready.
  assign taken = hsel && htrans[1] && hready;
  // Remembers the address of a write whose data phase is on the bus.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wr_addr <= 8'hff;
    else wr_addr <= (taken && hwrite) ? haddr[7:0] : 8'hff;
  end
  // Once a direct powerdown was asked for, entry timing no longer follows the auto timer.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) direct_seen <= 1'b0;
    else if ((wr_addr == 8'h10 && hwdata[6]) || (wr_addr == 8'h20 && hwdata[1])) direct_seen <= 1'b1;
  end
  // Counts the cycles for which every powerdown condition has held.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) idle_run <= 8'h00;
    else if (drive_output_control[7:4] != 4'h0 || main_status != 8'h80 || core_int
             || !head_unload_expired) idle_run <= 8'h00;
    else if (idle_run != 8'hff) idle_run <= idle_run + 8'h01;
  end
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_one_wait: assert property (taken && hreadyout |=> !hreadyout ##1 hreadyout)
    else $error("transfer did not take one wait state");
  a_pins_float: assert property (fdc_powered_down |-> drv_oe == 10'h000)
    else $error("drive pins driven in powerdown");
  a_pins_live: assert property (!fdc_powered_down && $past(hresetn) |-> drv_oe == 10'h3ff)
    else $error("drive pins floating while awake");
  a_act_follows: assert property ($past(hresetn) |-> act == $past(core_act))
    else $error("active drive outputs not following the core");
  a_auto_cause: assert property ($rose(fdc_powered_down) && !direct_seen |-> $past(idle_run) >= PD_CYCLES - 2)
    else $error("powerdown entered before conditions held long enough");
  a_msr_wake: assert property (taken && !hwrite && haddr[7:0] == 8'h10 && fdc_powered_down && !direct_seen |-> ##[1:3] !fdc_powered_down)
    else $error("main status read did not wake");
  a_data_wake: assert property (taken && haddr[7:0] == 8'h14 && fdc_powered_down && !direct_seen |-> ##[1:3] !fdc_powered_down)
    else $error("data register access did not wake");
  a_quiet_read: assert property (taken && !hwrite && haddr[7:0] inside {8'h00, 8'h04, 8'h08, 8'h1c} && fdc_powered_down |=> fdc_powered_down [*2])
    else $error("non-waking read woke the controller");
  a_soft_reset: assert property (wr_addr == 8'h08 && !hwdata[2] && fdc_powered_down |-> ##[0:2] core_reset)
    else $error("software reset did not reset the core");
endmodule : fapd_ctrl_props
bind fapd_ctrl fapd_ctrl_props #(.PD_CYCLES(PD_CYCLES)) fapd_ctrl_props_i (.*);
`default_nettype wire

//--- verification/fapd_core_model.sv
// Behavioural floppy core that feeds status and drive signals to the controller.
`timescale 1ns/1ps
`default_nettype none
module fapd_core_model (
  // Clock and reset.
  input wire logic            hclk,
  input wire logic            hresetn,
  // Scenario controls.
  input wire logic            busy,
  input wire logic            int_hi,
  input wire logic            hu_wait,
  // Status toward the controller.
  output logic [7:0]          status_a,
  output logic [7:0]          status_b,
  output logic [7:0]          main_status,
  output logic [7:0]          drive_input_status,
  output logic [7:0]          cmd_rd_data,
  output logic                core_int,
  output logic                head_unload_expired,
  output fapd_pkg::fapd_act_s core_act
);
  logic [4:0] act_cnt;
  // Fixed patterns let each register read be told apart.
  assign status_a = 8'h5a;
  assign status_b = 8'h66;
  assign drive_input_status = 8'hc3;
  assign cmd_rd_data = 8'h3c;
  // A busy core shows the command-in-progress bit instead of the idle value.
  assign main_status = busy ? 8'h10 : 8'h80;
  assign core_int = int_hi;
  assign head_unload_expired = !hu_wait;
  assign core_act = act_cnt;
  // Drive outputs keep moving so a stale copy is caught.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) act_cnt <= 5'h00;
    else act_cnt <= act_cnt + 5'h01;
  end
endmodule : fapd_core_model
`default_nettype wire

//--- verification/fapd_ctrl_bench.sv
// Self-checking bench for the floppy auto powerdown controller.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module fapd_ctrl_bench;
  localparam int PDC = 20;
  localparam logic [3:0] I_DOR = fapd_pkg::IDX_DRV_OUT;
  localparam logic [3:0] I_MSR = fapd_pkg::IDX_RATE_MAIN;
  localparam logic [3:0] I_CFG = fapd_pkg::IDX_PD_CFG;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, busy = 0, int_hi = 0, hu_wait = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic [7:0] sa, sb, ms, dis, crd, doc;
  logic hreadyout, cint, hue, crst, pd;
  logic [7:0] cwd, rsel, rcc;
  fapd_pkg::fapd_drv_s dv;
  int resets = 0;
  fapd_pkg::fapd_act_s cact;
  fapd_pkg::fapd_drv_s oe;
  int miscompares = 0, check_count = 0, cyc = 0;
  // Free-running bus clock.
  always #25 hclk = ~hclk;
  // Counts core reset cycles after hardware reset has been released.
  always @(posedge hclk) if (hresetn && crst) resets <= resets + 1;
  fapd_core_model fapd_core_model_i (.hclk(hclk), .hresetn(hresetn), .busy(busy),
    .int_hi(int_hi), .hu_wait(hu_wait), .status_a(sa), .status_b(sb), .main_status(ms),
    .drive_input_status(dis), .cmd_rd_data(crd), .core_int(cint), .head_unload_expired(hue),
    .core_act(cact));
  fapd_ctrl #(.PD_CYCLES(PDC)) fapd_ctrl_i (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
    .status_a(sa), .status_b(sb), .main_status(ms), .drive_input_status(dis),
    .cmd_rd_data(crd), .core_int(cint), .head_unload_expired(hue), .core_wdata_n(1'b1),
    .core_wgate_n(1'b1), .core_act(cact), .drive_output_control(doc), .rate_select(rsel),
    .rate_config_control(rcc), .cmd_wr_strobe(), .cmd_rd_strobe(), .cmd_wr_data(cwd),
    .core_reset(crst), .fdc_powered_down(pd), .drv(dv), .drv_oe(oe), .act());
  task automatic xfer(input logic w, input logic [3:0] ix, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {26'h0, ix, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : wt
  task automatic t_regs();
    xfer(0, I_DOR, 0); `CHK(rd[7:0], fapd_pkg::DOR_RESET)
    xfer(0, 4'hf, 0); `CHK(rd, 32'h0)
    xfer(1, fapd_pkg::IDX_STATUS_A, 8'hff);
    xfer(0, fapd_pkg::IDX_STATUS_A, 0); `CHK(rd[7:0], 8'h5a)
    xfer(0, fapd_pkg::IDX_CMD_DATA, 0); `CHK(rd[7:0], 8'h3c)
    xfer(1, fapd_pkg::IDX_DIN_CCR, 8'h01); wt(2); `CHK(rcc, 8'h01)
    $display("done: register access");
  endtask : t_regs
  task automatic t_auto();
    xfer(1, I_CFG, 8'h01); wt(PDC + 6); `CHK(pd, 1'b1)
    `CHK(oe, 10'h000)
    xfer(0, I_DOR, 0); xfer(0, fapd_pkg::IDX_STATUS_B, 0); xfer(0, fapd_pkg::IDX_DIN_CCR, 0);
    wt(2); `CHK(pd, 1'b1)
    `CHK(rd[7:0], 8'hc3)
    xfer(1, I_DOR, 8'h0c); wt(2); `CHK(pd, 1'b1)
    `CHK(doc, fapd_pkg::DOR_RESET)
    xfer(0, I_MSR, 0); wt(2); `CHK(pd, 1'b0)
    `CHK(doc, 8'h0c)
    wt(PDC / 2); `CHK(pd, 1'b0)
    wt(PDC); `CHK(pd, 1'b1)
    xfer(1, fapd_pkg::IDX_CMD_DATA, 8'h11); wt(2); `CHK(pd, 1'b0)
    `CHK(cwd, 8'h11)
    wt(PDC + 6); `CHK(pd, 1'b1)
    $display("done: auto powerdown and wake");
  endtask : t_auto
  task automatic t_conds();
    int n;
    xfer(1, I_DOR, 8'h1c); wt(2); `CHK(pd, 1'b0)
    `CHK(dv.motor_n, 4'he)
    wt(PDC * 2); `CHK(pd, 1'b0)
    xfer(1, I_DOR, 8'h0c);
    busy <= 1'b1;
    wt(PDC * 2); `CHK(pd, 1'b0)
    @(posedge hclk) {busy, int_hi} <= 2'b01;
    wt(PDC * 2); `CHK(pd, 1'b0)
    @(posedge hclk) {int_hi, hu_wait} <= 2'b01;
    wt(PDC * 2); `CHK(pd, 1'b0)
    @(posedge hclk) hu_wait <= 1'b0;
    wt(PDC / 2);
    xfer(1, I_CFG, 8'h00); wt(PDC * 2); `CHK(pd, 1'b0)
    xfer(1, I_CFG, 8'h01); wt(PDC + 6); `CHK(pd, 1'b1)
    n = resets;
    xfer(1, I_DOR, 8'h08); wt(2); `CHK(pd, 1'b0)
    `CHK(resets - n, 1)
    xfer(1, I_DOR, 8'h0c);
    $display("done: powerdown conditions");
  endtask : t_conds
  task automatic t_direct();
    xfer(1, I_MSR, 8'h42); wt(4); `CHK(pd, 1'b1)
    `CHK(rsel, 8'h42)
    xfer(0, I_MSR, 0); wt(2); `CHK(pd, 1'b1)
    xfer(1, I_MSR, 8'h02); wt(2); `CHK(pd, 1'b0)
    wt(PDC + 6); `CHK(pd, 1'b1)
    $display("done: direct powerdown");
  endtask : t_direct
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  // Cuts a hung run short.
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares++;
      close_out();
    end
  end
  // Main sequence.
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_auto();
    t_conds();
    t_direct();
    close_out();
  end
endmodule : fapd_ctrl_bench
`default_nettype wire
